// File: pkg/phpc_map.svh
`ifndef PHPC_MAP_SVH
`define PHPC_MAP_SVH
// register selectors on the host port
`define PHPC_A_CTRL_A 5'h00
`define PHPC_A_CTRL_B 5'h01
`define PHPC_A_MASK 5'h02
`define PHPC_A_VECTOR 5'h03
`define PHPC_A_VEC_LEN 5'h04
`define PHPC_A_CONN_PRE 5'h0e
`define PHPC_A_NOISE_PRE 5'h0f
`define PHPC_A_STATUS_A 5'h10
`define PHPC_A_EVENT 5'h17
`define PHPC_A_VIOL 5'h18
`define PHPC_A_IDLE 5'h19
`define PHPC_A_LINK 5'h1a
`define PHPC_A_LAST_RW 5'h0d
`define PHPC_A_LAST 5'h1a
// control_reg_a fields
`define PHPC_B_NOISE_TIMER 14
`define PHPC_B_LOOPBACK 7
`define PHPC_B_QUIET 6
`define PHPC_B_BUF_LOOP 5
`define PHPC_B_MON_LOOP 4
`define PHPC_B_CD_LOOP 2
`define PHPC_B_SELF_TEST 0
// control_reg_b service line state field
`define PHPC_B_SVC_LS_LO 0
`define PHPC_B_SVC_LS_HI 2
`define PHPC_LS_REQ_QUIET 3'h0
// interrupt_event_reg fields
`define PHPC_B_HOST_ERR 15
`define PHPC_B_SIG_LOST 14
// status_reg_a fields
`define PHPC_B_SIG_DET 15
`define PHPC_B_UNKNOWN 3
`define PHPC_B_LS_LO 0
`define PHPC_B_LS_HI 2
// reset values
`define PHPC_RST_WORD 16'h0000
`define PHPC_SYM_QUIET 5'h00
`define PHPC_LS_NOISE 3'h0
`endif

// File: pkg/phpc_pkg.sv
package phpc_pkg;
    // host port request bundle
    typedef struct packed {
        logic cs_n;
        logic dir;
        logic [4:0] sel;
    } phpc_req_t;
    // mode select decode
    typedef enum logic [2:0] {
        PHPC_MODE_NORMAL,
        PHPC_MODE_SEG_TEST,
        PHPC_MODE_SCAN_SER,
        PHPC_MODE_SCAN_PAR,
        PHPC_MODE_FLOAT
    } phpc_mode_t;
    // line status bundle from the line state machine
    typedef struct packed {
        logic [2:0] state;
        logic unknown;
    } phpc_line_t;
endpackage

// File: src/phpc_top.sv
`timescale 1ns/1ns
`include "phpc_map.svh"
// How it works
// - direction high reads, low writes
// - shared 16-bit data bus, one driver
// - reset puts state machines idle
// - reset clears writable and clear-on-read registers
// - reset forces quiet, transmitter off, loopback
// - loopback low selects transmitter data
// - transmitter off on bits, service, request, test
// - signal detect held; loss sets flag
// - mode pins choose normal, test, scan
// - encoder disable bypasses symbol encoding
// - line state on three pins, unknown pin
// - reads change nothing but clear-on-read registers
// - access starts on select sampled low
// - drive bus from the edge that samples select
// - data valid second edge, held two
// - held select extends read until select rises
// - bad write sets error, no change
// - one write per select assertion
// - address selects one register
// - interrupt held until event register read
module phpc_top
(
    input wire logic CLK, // host port clock, 25 MHz
    input wire logic SRST, // synchronous reset, high
    input wire phpc_pkg::phpc_req_t HOST_REQ, // select, direction, register select
    input wire logic [15:0] HOST_DATA_IN, // host_data_bus as seen on the pin
    output logic [15:0] HOST_DATA_OUT, // host_data_bus drive value
    output logic HOST_DATA_OE, // high while device drives bus
    output logic INT_N, // interrupt request, active low
    input wire logic SIGNAL_DETECT_IN, // optical signal present
    input wire logic [2:0] TEST_MODE_IN, // mode select pins
    input wire logic ENCODER_DISABLE, // bypass symbol encoding
    input wire logic [4:0] RAW_SYMBOL_IN, // symbol when encoder is bypassed
    input wire logic [4:0] CODED_SYMBOL_IN, // symbol from encoder
    input wire logic [2:0] REQUESTED_LINE_STATE, // from connection management
    input wire logic SERVICE_STATE, // connection management in service state
    input wire phpc_pkg::phpc_line_t LINE_IN, // line state from receiver
    input wire logic [2:0] VIOL_INC, // violation, short idle, link error events
    input wire logic SCAN_CHAIN_IN, // end of boundary scan chain
    output logic LOOPBACK_SELECT_OUT_N, // low takes transmitter data
    output logic TRANSMITTER_QUIET_OUT_N, // low turns transmitter off
    output logic [4:0] SYMBOL_OUT_BUS, // symbols to the transmitter
    output logic [2:0] LINE_STATE_PINS, // line_state_field on pins
    output logic UNKNOWN_STATE_PIN, // unknown_state_bit on pin
    output logic SCAN_CHAIN_OUT, // scan output
    output logic OUTPUTS_FLOAT, // all outputs to high impedance
    output logic [2:0] MODE_OUT // decoded operating mode
);
    import phpc_pkg::*;

    // access sequencer states; idle is the not-active state
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READ, ST_HOLD} phpc_st_t;
    phpc_st_t state_reg;
    logic [4:0] sel_reg; // latched register select
    logic dir_reg; // latched direction
    logic [1:0] hold_reg; // edges left before release
    logic [15:0] ctrl_a_reg; // control_reg_a
    logic [15:0] ctrl_b_reg; // control_reg_b
    logic [15:0] mask_reg; // interrupt mask
    logic [15:0] vector_reg; // signal_out_vector
    logic [15:0] vec_len_reg; // signal_vector_len
    logic [15:0] conn_pre_reg; // conn_timer_preload
    logic [15:0] noise_pre_reg; // noise_timer_preload
    logic [15:0] spare_reg [8]; // plain timing words 05..09 and 0b..0d
    logic [15:0] event_reg; // interrupt_event_reg
    logic [15:0] cnt_reg [3]; // violation, short idle, link error
    logic sig_det_reg; // held signal detect level
    logic signaling; // vector registers locked while signalling
    logic [15:0] rd_data; // selected register
    logic wr_go; // write taken this edge
    logic rd_take; // read data captured this edge
    logic wr_legal; // target accepts write now
    logic [15:0] status_a; // status_reg_a view
    logic start_ok; // sequencer may take a new select this edge

    // signalling state is outside this block; treat every state as not signalling
    assign signaling = 1'b0;
    assign status_a = {sig_det_reg, 11'h000, LINE_IN.unknown, LINE_IN.state};
    // the last edge of a read may already open the next access, keeping reads two clocks apart
    assign start_ok = (state_reg == ST_IDLE) || (state_reg == ST_READ && hold_reg == 2'h1);

    // access sequencer
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_reg <= ST_IDLE;
            sel_reg <= 5'h00;
            dir_reg <= 1'b0;
            hold_reg <= 2'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (!HOST_REQ.cs_n)
                    begin
                        sel_reg <= HOST_REQ.sel;
                        dir_reg <= HOST_REQ.dir;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // second edge: read data captured or write taken
                    if (dir_reg)
                    begin
                        state_reg <= ST_READ;
                        hold_reg <= HOST_REQ.cs_n ? 2'h1 : 2'h2; // select sampled at second edge
                    end
                    else if (HOST_REQ.cs_n)
                        state_reg <= ST_IDLE;
                    else
                        state_reg <= ST_HOLD;
                end
                ST_READ:
                begin
                    // hold 2: select still held; hold 1: released, this edge ends the read
                    if (hold_reg == 2'h1)
                    begin
                        state_reg <= ST_IDLE;
                        if (!HOST_REQ.cs_n) // select low again is a new access
                        begin
                            sel_reg <= HOST_REQ.sel;
                            dir_reg <= HOST_REQ.dir;
                            state_reg <= ST_WAIT;
                        end
                    end
                    else if (HOST_REQ.cs_n)
                        hold_reg <= 2'h1;
                    else
                        hold_reg <= 2'h2;
                end
                ST_HOLD:
                begin
                    // wait for select release before another write
                    if (HOST_REQ.cs_n)
                        state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign wr_go = (state_reg == ST_WAIT) && !dir_reg;
    assign rd_take = (state_reg == ST_WAIT) && dir_reg;

    // register read mux
    always_comb
    begin
        rd_data = `PHPC_RST_WORD;
        if (sel_reg >= 5'h05 && sel_reg <= `PHPC_A_LAST_RW && sel_reg != 5'h0a)
            rd_data = spare_reg[3'(sel_reg > 5'h0a ? sel_reg - 5'h06 : sel_reg - 5'h05)];
        else
        begin
            unique case (sel_reg)
                `PHPC_A_CTRL_A: rd_data = ctrl_a_reg;
                `PHPC_A_CTRL_B: rd_data = ctrl_b_reg;
                `PHPC_A_MASK: rd_data = mask_reg;
                `PHPC_A_VECTOR: rd_data = vector_reg;
                `PHPC_A_VEC_LEN: rd_data = vec_len_reg;
                `PHPC_A_STATUS_A: rd_data = status_a;
                `PHPC_A_EVENT: rd_data = event_reg;
                `PHPC_A_VIOL: rd_data = cnt_reg[0];
                `PHPC_A_IDLE: rd_data = cnt_reg[1];
                `PHPC_A_LINK: rd_data = cnt_reg[2];
                default: rd_data = `PHPC_RST_WORD; // write-only and unmapped read zero
            endcase
        end
    end

    // which targets take a write now
    always_comb
    begin
        wr_legal = 1'b0;
        if (sel_reg <= `PHPC_A_LAST_RW && sel_reg != 5'h0a)
            wr_legal = 1'b1;
        if ((sel_reg == `PHPC_A_VECTOR || sel_reg == `PHPC_A_VEC_LEN) && signaling)
            wr_legal = 1'b0;
        if (sel_reg == `PHPC_A_CONN_PRE)
            wr_legal = SERVICE_STATE;
        if (sel_reg == `PHPC_A_NOISE_PRE)
            wr_legal = SERVICE_STATE && !ctrl_a_reg[`PHPC_B_NOISE_TIMER];
    end

    // writable registers
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ctrl_a_reg <= `PHPC_RST_WORD;
            ctrl_b_reg <= `PHPC_RST_WORD;
            mask_reg <= `PHPC_RST_WORD;
            vector_reg <= `PHPC_RST_WORD;
            vec_len_reg <= `PHPC_RST_WORD;
            conn_pre_reg <= `PHPC_RST_WORD;
            noise_pre_reg <= `PHPC_RST_WORD;
        end
        else if (wr_go && wr_legal)
        begin
            unique case (sel_reg)
                `PHPC_A_CTRL_A: ctrl_a_reg <= HOST_DATA_IN;
                `PHPC_A_CTRL_B: ctrl_b_reg <= HOST_DATA_IN;
                `PHPC_A_MASK: mask_reg <= HOST_DATA_IN;
                `PHPC_A_VECTOR: vector_reg <= HOST_DATA_IN;
                `PHPC_A_VEC_LEN: vec_len_reg <= HOST_DATA_IN;
                `PHPC_A_CONN_PRE: conn_pre_reg <= HOST_DATA_IN;
                `PHPC_A_NOISE_PRE: noise_pre_reg <= HOST_DATA_IN;
                default: ; // timing words handled in their own loop
            endcase
        end
    end

    // plain timing words, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_spare
            localparam logic [4:0] ADDR = 5'(gi < 5 ? gi + 5 : gi + 6);
            always_ff @(posedge CLK)
            begin
                if (SRST)
                    spare_reg[gi] <= `PHPC_RST_WORD;
                else if (wr_go && wr_legal && sel_reg == ADDR)
                    spare_reg[gi] <= HOST_DATA_IN;
            end
        end
        // error and idle counters, cleared once on read
        for (gi = 0; gi < 3; gi++)
        begin : g_cnt
            always_ff @(posedge CLK)
            begin
                if (SRST)
                    cnt_reg[gi] <= `PHPC_RST_WORD;
                else if (rd_take && sel_reg == 5'(`PHPC_A_VIOL + gi))
                    cnt_reg[gi] <= {15'h0000, VIOL_INC[gi]}; // event not lost
                else if (VIOL_INC[gi] && cnt_reg[gi] != 16'hffff)
                    cnt_reg[gi] <= cnt_reg[gi] + 16'h0001;
            end
        end
    endgenerate

    // interrupt events and signal detect
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            event_reg <= `PHPC_RST_WORD;
            sig_det_reg <= 1'b0;
        end
        else
        begin
            logic [15:0] ev_set;
            ev_set = `PHPC_RST_WORD;
            sig_det_reg <= SIGNAL_DETECT_IN;
            ev_set[`PHPC_B_SIG_LOST] = sig_det_reg && !SIGNAL_DETECT_IN;
            ev_set[`PHPC_B_HOST_ERR] = wr_go && !wr_legal;
            if (rd_take && sel_reg == `PHPC_A_EVENT)
                event_reg <= ev_set; // new set wins over clear
            else
                event_reg <= event_reg | ev_set;
        end
    end

    // host bus drive: enable registered so it rises at the edge that samples select
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            HOST_DATA_OE <= 1'b0;
            HOST_DATA_OUT <= `PHPC_RST_WORD;
        end
        else
        begin
            // drive from the sampling edge itself; data valid at second edge
            HOST_DATA_OE <= (start_ok && !HOST_REQ.cs_n && HOST_REQ.dir)
                || (state_reg == ST_WAIT && dir_reg)
                || (state_reg == ST_READ && hold_reg == 2'h2);
            if (rd_take)
                HOST_DATA_OUT <= rd_data;
        end
    end

    // pin outputs
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            INT_N <= 1'b1;
            LOOPBACK_SELECT_OUT_N <= 1'b0;
            TRANSMITTER_QUIET_OUT_N <= 1'b0;
            SYMBOL_OUT_BUS <= `PHPC_SYM_QUIET;
            LINE_STATE_PINS <= `PHPC_LS_NOISE;
            UNKNOWN_STATE_PIN <= 1'b0;
            SCAN_CHAIN_OUT <= 1'b0;
            OUTPUTS_FLOAT <= 1'b0;
            MODE_OUT <= PHPC_MODE_NORMAL;
        end
        else
        begin
            INT_N <= ~|(event_reg & mask_reg);
            LOOPBACK_SELECT_OUT_N <= ~(ctrl_a_reg[`PHPC_B_LOOPBACK] | ctrl_a_reg[`PHPC_B_CD_LOOP]);
            TRANSMITTER_QUIET_OUT_N <= ~(ctrl_a_reg[`PHPC_B_QUIET] | ctrl_a_reg[`PHPC_B_CD_LOOP]
                | ctrl_a_reg[`PHPC_B_BUF_LOOP] | ctrl_a_reg[`PHPC_B_MON_LOOP]
                | (SERVICE_STATE && ctrl_b_reg[`PHPC_B_SVC_LS_HI:`PHPC_B_SVC_LS_LO] == `PHPC_LS_REQ_QUIET)
                | (REQUESTED_LINE_STATE == `PHPC_LS_REQ_QUIET)
                | ctrl_a_reg[`PHPC_B_SELF_TEST]);
            SYMBOL_OUT_BUS <= ENCODER_DISABLE ? RAW_SYMBOL_IN : CODED_SYMBOL_IN;
            LINE_STATE_PINS <= LINE_IN.state;
            UNKNOWN_STATE_PIN <= LINE_IN.unknown;
            SCAN_CHAIN_OUT <= (TEST_MODE_IN[2:1] == 2'h2) ? SCAN_CHAIN_IN : 1'b0;
            OUTPUTS_FLOAT <= (TEST_MODE_IN == 3'h7);
            unique case (TEST_MODE_IN)
                3'h1: MODE_OUT <= PHPC_MODE_SEG_TEST;
                3'h4, 3'h5: MODE_OUT <= PHPC_MODE_SCAN_SER;
                3'h6: MODE_OUT <= PHPC_MODE_SCAN_PAR;
                3'h7: MODE_OUT <= PHPC_MODE_FLOAT;
                default: MODE_OUT <= PHPC_MODE_NORMAL;
            endcase
        end
    end

    // checks
    a_write_once: assert property (@(posedge CLK) disable iff (SRST)
        wr_go |=> !wr_go) else $error("second write in one select");
    a_read_drive: assert property (@(posedge CLK) disable iff (SRST)
        rd_take |=> HOST_DATA_OE) else $error("read data not driven");
    a_read_hold: assert property (@(posedge CLK) disable iff (SRST)
        (state_reg == ST_READ && hold_reg == 2'h2 && !HOST_REQ.cs_n) |=> HOST_DATA_OE [*2])
        else $error("extension lost");
    a_no_drive_wr: assert property (@(posedge CLK) disable iff (SRST)
        (state_reg == ST_HOLD) |-> !HOST_DATA_OE) else $error("drove bus in write");
    a_err_flag: assert property (@(posedge CLK) disable iff (SRST)
        (wr_go && !wr_legal) |=> event_reg[`PHPC_B_HOST_ERR]) else $error("host error not set");
    a_bad_nochange: assert property (@(posedge CLK) disable iff (SRST)
        (wr_go && !wr_legal) |=> $stable(ctrl_a_reg) && $stable(conn_pre_reg)) else $error("bad write stored");
    a_sig_lost: assert property (@(posedge CLK) disable iff (SRST)
        $fell(sig_det_reg) |-> event_reg[`PHPC_B_SIG_LOST]) else $error("signal loss missed");
    a_quiet_bit: assert property (@(posedge CLK) disable iff (SRST)
        ctrl_a_reg[`PHPC_B_QUIET] |=> !TRANSMITTER_QUIET_OUT_N) else $error("transmitter not off");
    a_reset_out: assert property (@(posedge CLK)
        SRST |=> !TRANSMITTER_QUIET_OUT_N && !LOOPBACK_SELECT_OUT_N) else $error("reset outputs wrong");
    a_sel_stable: assert property (@(posedge CLK) disable iff (SRST)
        (state_reg == ST_WAIT || state_reg == ST_HOLD || (state_reg == ST_READ && hold_reg == 2'h2))
        |=> $stable(sel_reg)) else $error("select moved");
endmodule // phpc_top

// File: testbench/phpc_host_bfm.sv
`timescale 1ns/1ns
// host processor model, drives the register port on falling edges
module phpc_host_bfm
(
    input wire logic clk, // host port clock
    input wire logic [15:0] dev_data, // device drive value
    input wire logic dev_oe, // device drives bus
    output phpc_pkg::phpc_req_t req, // select, direction, selector
    output logic [15:0] bus, // resolved bus level
    output logic clash // both sides drove at once
);
    import phpc_pkg::*;
    logic [15:0] drv_val = 16'h0000; // host drive value
    logic drv_en = 1'b0; // host drives bus
    logic [15:0] last_val = 16'h0000; // last driven level
    logic fight = 1'b0; // sticky, both sides drove at once
    assign clash = fight;
    initial
    begin
        req = '{cs_n: 1'b1, dir: 1'b1, sel: 5'h00};
    end
    // a released bus shows the inverse of its last level, so stale data never matches
    always_comb
    begin
        if (dev_oe)
            bus = dev_data;
        else if (drv_en)
            bus = drv_val;
        else
            bus = ~last_val;
    end
    // remember the driven level, flag any fight on the bus
    always @(posedge clk)
    begin
        if (dev_oe | drv_en)
            last_val <= bus;
        if (dev_oe & drv_en)
            fight <= 1'b1;
    end
    // read; hold extends select, steady tells data held to the end
    task automatic rd(input logic [4:0] sel, input int hold, output logic [15:0] data, output logic to,
        output logic steady);
        int n;
        @(negedge clk);
        req = '{cs_n: 1'b0, dir: 1'b1, sel: sel};
        @(negedge clk);
        req.sel = ~sel;
        if (hold == 0)
            req.cs_n = 1'b1;
        @(negedge clk);
        data = bus;
        repeat (hold) @(negedge clk);
        steady = (bus === data) && dev_oe;
        req.cs_n = 1'b1;
        n = 0;
        while (dev_oe && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        to = dev_oe;
    endtask
    // write; hold keeps select low after the bus is released
    task automatic wr(input logic [4:0] sel, input logic [15:0] val, input int hold);
        @(negedge clk);
        req = '{cs_n: 1'b0, dir: 1'b0, sel: sel};
        drv_val = val;
        drv_en = 1'b1;
        repeat (2) @(negedge clk);
        drv_en = 1'b0;
        repeat (hold) @(negedge clk);
        req.cs_n = 1'b1;
        @(negedge clk);
    endtask
endmodule // phpc_host_bfm

// File: testbench/phpc_top_tb.sv
`timescale 1ns/1ns
`include "phpc_map.svh"
// register port bench: call sequences with worked-out expectations
module phpc_top_tb;
    import phpc_pkg::*;
    logic clk = 1'b0; // 25 MHz port clock
    logic srst = 1'b1; // synchronous reset
    phpc_req_t req; // host request
    logic [15:0] bus, dout; // bus level, device value
    logic oe, int_n, sdi, enc_dis, svc, clash, scan_in, scan_out; // loose bits
    logic [2:0] test_mode, req_ls, viol_inc, pins; // mode, request, events, line pins
    logic [4:0] raw, coded, sym; // symbol paths
    phpc_line_t line; // receiver line state
    logic loop_n, quiet_n, unk, fl; // pin outputs
    logic [2:0] mode; // decoded mode as the pins carry it
    int err_count = 0; // mismatches
    int checks_done = 0; // comparisons
    always #20 clk = ~clk;
    phpc_host_bfm i_phpc_host_bfm (.clk(clk), .dev_data(dout), .dev_oe(oe), .req(req), .bus(bus), .clash(clash));
    phpc_top i_phpc_top (.CLK(clk), .SRST(srst), .HOST_REQ(req), .HOST_DATA_IN(bus), .HOST_DATA_OUT(dout),
        .HOST_DATA_OE(oe), .INT_N(int_n), .SIGNAL_DETECT_IN(sdi), .TEST_MODE_IN(test_mode),
        .ENCODER_DISABLE(enc_dis), .RAW_SYMBOL_IN(raw), .CODED_SYMBOL_IN(coded), .REQUESTED_LINE_STATE(req_ls),
        .SERVICE_STATE(svc), .LINE_IN(line), .VIOL_INC(viol_inc), .SCAN_CHAIN_IN(scan_in),
        .LOOPBACK_SELECT_OUT_N(loop_n), .TRANSMITTER_QUIET_OUT_N(quiet_n), .SYMBOL_OUT_BUS(sym),
        .LINE_STATE_PINS(pins), .UNKNOWN_STATE_PIN(unk), .SCAN_CHAIN_OUT(scan_out), .OUTPUTS_FLOAT(fl),
        .MODE_OUT(mode));
    // verdict in one place
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // word compare
    task automatic chk_w(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // bit compare
    task automatic chk_b(input string name, input logic exp, input logic got);
        chk_w(name, {15'h0000, exp}, {15'h0000, got});
    endtask
    // read through the host model and compare the masked word
    task automatic rd_chk(input string name, input logic [4:0] sel, input int hold, input logic [15:0] exp,
        input logic [15:0] mask);
        logic [15:0] d;
        logic to, st;
        i_phpc_host_bfm.rd(sel, hold, d, to, st);
        if (to)
        begin
            err_count++;
            $display("BAD %s bus never released", name);
            tally_and_finish();
        end
        chk_w(name, exp, d & mask);
        chk_b(name, 1'b1, st);
    endtask
    // idle cycles, inputs settle through the registered outputs
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // main sequence
    initial
    begin
        int qb[5] = '{6, 5, 4, 2, 0};
        logic [4:0] bad[5] = '{`PHPC_A_STATUS_A, `PHPC_A_CONN_PRE, 5'h0a, `PHPC_A_LINK, `PHPC_A_NOISE_PRE};
        logic [4:0] ctr[3] = '{`PHPC_A_VIOL, `PHPC_A_IDLE, `PHPC_A_LINK};
        phpc_mode_t md[8] = '{PHPC_MODE_NORMAL, PHPC_MODE_SEG_TEST, PHPC_MODE_NORMAL, PHPC_MODE_NORMAL,
            PHPC_MODE_SCAN_SER, PHPC_MODE_SCAN_SER, PHPC_MODE_SCAN_PAR, PHPC_MODE_FLOAT};
        sdi = 1'b1;
        test_mode = 3'h0;
        enc_dis = 1'b0;
        raw = 5'h15;
        coded = 5'h0a;
        req_ls = 3'h1;
        svc = 1'b0;
        line = '{state: 3'h3, unknown: 1'b0};
        viol_inc = 3'h0;
        scan_in = 1'b1;
        cyc(1);
        chk_b("oe in reset", 1'b0, oe);
        chk_b("quiet in reset", 1'b0, quiet_n);
        chk_b("loop in reset", 1'b0, loop_n);
        chk_w("symbol in reset", 16'h0000, {11'h000, sym});
        chk_b("int in reset", 1'b1, int_n);
        cyc(2);
        srst = 1'b0;
        rd_chk("ctrl a reset", `PHPC_A_CTRL_A, 0, 16'h0000, 16'hffff);
        rd_chk("event reset", `PHPC_A_EVENT, 0, 16'h0000, 16'hffff);
        i_phpc_host_bfm.wr(`PHPC_A_CTRL_A, 16'h0000, 0);
        cyc(3);
        chk_b("quiet off", 1'b1, quiet_n);
        chk_b("loop off", 1'b1, loop_n);
        chk_w("symbol coded", 16'h000a, {11'h000, sym});
        enc_dis = 1'b1;
        cyc(3);
        chk_w("symbol raw", 16'h0015, {11'h000, sym});
        enc_dis = 1'b0;
        i_phpc_host_bfm.wr(`PHPC_A_CTRL_A, 16'h0080, 0);
        cyc(3);
        chk_b("loop on", 1'b0, loop_n);
        rd_chk("ctrl a back", `PHPC_A_CTRL_A, 0, 16'h0080, 16'hffff);
        for (int i = 0; i < 5; i++)
        begin
            i_phpc_host_bfm.wr(`PHPC_A_CTRL_A, 16'h0001 << qb[i], 0);
            cyc(3);
            chk_b("quiet by bit", 1'b0, quiet_n);
        end
        i_phpc_host_bfm.wr(`PHPC_A_CTRL_A, 16'h0000, 0);
        svc = 1'b1;
        cyc(3);
        chk_b("quiet by service", 1'b0, quiet_n);
        i_phpc_host_bfm.wr(`PHPC_A_CTRL_B, 16'h0001, 0);
        cyc(3);
        chk_b("service not quiet", 1'b1, quiet_n);
        i_phpc_host_bfm.wr(`PHPC_A_CONN_PRE, 16'h1234, 0);
        rd_chk("legal preload", `PHPC_A_EVENT, 0, 16'h0000, 16'hffff);
        svc = 1'b0;
        req_ls = 3'h0;
        cyc(3);
        chk_b("quiet by request", 1'b0, quiet_n);
        req_ls = 3'h1;
        i_phpc_host_bfm.wr(`PHPC_A_MASK, 16'h8000, 0);
        for (int i = 0; i < 5; i++)
        begin
            i_phpc_host_bfm.wr(bad[i], 16'hffff, 0);
            cyc(2);
            chk_b("int raised", 1'b0, int_n);
            rd_chk("host error", `PHPC_A_EVENT, 0, 16'h8000, 16'hffff);
            cyc(2);
            chk_b("int cleared", 1'b1, int_n);
        end
        rd_chk("event cleared", `PHPC_A_EVENT, 0, 16'h0000, 16'hffff);
        i_phpc_host_bfm.wr(`PHPC_A_CTRL_A, 16'h0080, 3);
        rd_chk("one write", `PHPC_A_CTRL_A, 0, 16'h0080, 16'hffff);
        i_phpc_host_bfm.wr(`PHPC_A_LAST_RW, 16'h5a5a, 0);
        rd_chk("timing word", `PHPC_A_LAST_RW, 0, 16'h5a5a, 16'hffff);
        rd_chk("status detect", `PHPC_A_STATUS_A, 0, 16'h8003, 16'h800f);
        sdi = 1'b0;
        cyc(3);
        rd_chk("signal lost", `PHPC_A_EVENT, 0, 16'h4000, 16'h4000);
        rd_chk("status no detect", `PHPC_A_STATUS_A, 0, 16'h0000, 16'h8000);
        for (int i = 0; i < 8; i++)
        begin
            line = '{state: 3'(i), unknown: i[0]};
            cyc(3);
            chk_w("line pins", 16'(i), {13'h0000, pins});
            chk_b("unknown pin", i[0], unk);
        end
        rd_chk("status line", `PHPC_A_STATUS_A, 0, 16'h000f, 16'h000f);
        for (int k = 0; k < 3; k++)
        begin
            repeat (k + 1)
            begin
                viol_inc = 3'h1 << k;
                cyc(1);
            end
            viol_inc = 3'h0;
            cyc(2);
            rd_chk("counter", ctr[k], k, 16'(k + 1), 16'hffff);
            rd_chk("counter cleared", ctr[k], 0, 16'h0000, 16'hffff);
        end
        // warm reset in mid-run, held the full twenty clocks
        srst = 1'b1;
        cyc(20);
        chk_b("quiet in warm reset", 1'b0, quiet_n);
        chk_b("loop in warm reset", 1'b0, loop_n);
        srst = 1'b0;
        rd_chk("ctrl a warm reset", `PHPC_A_CTRL_A, 0, 16'h0000, 16'hffff);
        for (int i = 0; i < 8; i++)
        begin
            test_mode = 3'(i);
            cyc(3);
            chk_w("mode", {13'h0000, md[i]}, {13'h0000, mode});
            chk_b("float", i == 7, fl);
            chk_b("scan out", i[2:1] == 2'h2, scan_out);
        end
        test_mode = 3'h0;
        chk_b("bus clash", 1'b0, clash);
        tally_and_finish();
    end
endmodule // phpc_top_tb
